//--- rtl/bus_seq.sv
// Bus master sequencer for indivisible read-modify-write and breakpoint
// acknowledge cycles. Assumes synchronous inputs and one system clock.
// Contract
// [RULE1] Locked flag spans first read to last write
// [RULE2] No bus grant during locked sequence
// [RULE3] S0 read: flag, address, codes, read direction
// [RULE4] S1: address and data strobes asserted
// [RULE5] Slave drives byte lanes, may acknowledge
// [RULE6] Ack by S2 end: latch, end cycle
// [RULE7] No ack by S3: wait, resample each fall
// [RULE8] Waiting slave keeps acks negated near S2
// [RULE9] Strobes negate in S5; repeat per read
// [RULE10] Hold address, direction, codes after reads
// [RULE11] Slave holds data until strobes negate
// [RULE12] Idle: no strobes; skip write if unneeded
// [RULE13] Direction stays read; data from write S2
// [RULE14] Write S0 drives direction low, new address
// [RULE15] Write S1 strobes; S2 drives data
// [RULE16] Write S3 data strobe; ends clock later
// [RULE17] Write S5 negates strobes, holds, repeats; code runs one write only, then ST_END
// [RULE18] Private space: code seven, type on A19-16
// [RULE19] Software breakpoint: number on A4-2, A1 clear
// [RULE20] Software result: error illegal, else execute
// [RULE21] Hardware breakpoint: ones, A1 set, outcomes
// [RULE22] Breakpoint pin held until acknowledge seen
// [RULE23] Half-clock phases; reset returns to idle
`timescale 1ns/1ps
module bus_seq #(
  parameter int READ_MAX = 2
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic [1:0]  op,
  input  wire logic [31:0] op_addr,
  input  wire logic [1:0]  op_reads,
  input  wire logic        op_write,
  input  wire logic [31:0] wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic [1:0]  wr_size,
  input  wire logic [2:0]  breakpoint_pin_num,
  input  wire logic [2:0]  op_fc,
  input  wire logic [1:0]  op_size,
  input  wire logic        bus_request_in,
  input  wire logic [1:0]  transfer_ack_n,
  input  wire logic        bus_error_in_n,
  input  wire logic        breakpoint_pin_n,
  input  wire logic [15:0] data_in,
  output logic             busy,
  output logic             done,
  output logic [1:0]       result,
  output logic [15:0]      result_data,
  output logic             modify_phase,
  output logic             breakpoint_pin_seen,
  output logic             bus_grant_out,
  output logic             indivisible_cycle_flag_n,
  output logic             addr_strobe_n,
  output logic             data_strobe_n,
  output logic             upper_write_strobe_n,
  output logic             lower_write_strobe_n,
  output logic             read_write_dir,
  output logic [31:0]      address,
  output logic [2:0]       function_code,
  output logic             transfer_size_hi,
  output logic             transfer_size_lo,
  output logic [15:0]      data_out,
  output logic             data_oe
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000, ST_S0 = 4'b0001, ST_S1 = 4'b0010, ST_S2 = 4'b0011,
    ST_SW   = 4'b0100, ST_S4 = 4'b0101, ST_S5 = 4'b0110,
    ST_GAP  = 4'b0111, ST_END = 4'b1000
  } state_t;

  state_t      st_r;
  logic        wphase_r;
  logic        locked_r;
  logic [1:0]  op_r;
  logic [1:0]  reads_left_r;
  logic [1:0]  rd_cnt_r;
  logic        write_r;
  logic [31:0] waddr_r;
  logic [15:0] wdata_r;
  logic [1:0]  wsize_r;
  logic [3:0]  idle_cnt_r;
  logic        err_r;
  logic        breakpoint_pin_pend_r;
  logic        ack_now;

  cyc_if store_bus ();
  read_store #(.DEPTH(4)) u_store (.clk(clk), .rst_n(rst_n),
                                   .port(store_bus));

  assign ack_now = (transfer_ack_n != 2'h3) || !bus_error_in_n;

  function automatic logic [31:0] breakpoint_pin_addr(input logic [2:0] num,
                                            input logic       hw);
    logic [31:0] a;
    a = 32'h00000000;
    a[bus_seq_pkg::SPACE_LSB+3 -: 4] = bus_seq_pkg::SPACE_BREAKPOINT_PIN;  // RULE18
    a[bus_seq_pkg::BREAKPOINT_PIN_NUM_LSB +: 3] = num;
    a[bus_seq_pkg::BREAKPOINT_PIN_KIND_BIT] = hw;
    return a;
  endfunction : breakpoint_pin_addr

  // Sequencer; each state is one half-clock bus phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r         <= ST_IDLE; // RULE23
      wphase_r     <= 1'b0;
      idle_cnt_r   <= 4'h0;
      reads_left_r <= 2'h0;
      rd_cnt_r     <= 2'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (start) begin
            st_r         <= ST_S0;
            wphase_r     <= 1'b0;
            rd_cnt_r     <= 2'h0;
            reads_left_r <= (op == bus_seq_pkg::OP_RMW) ? op_reads :
                            2'h1;
          end
        end
        ST_S0: st_r <= ST_S1;
        ST_S1: st_r <= ST_S2;
        ST_S2: st_r <= ack_now ? ST_S4 : ST_SW; // RULE6 RULE7
        ST_SW: if (ack_now) st_r <= ST_S4; // RULE7
        ST_S4: st_r <= ST_S5;
        ST_S5: begin
          if (!wphase_r) begin
            rd_cnt_r <= rd_cnt_r + 2'h1;
            if (err_r || reads_left_r <= 2'h1) begin
              st_r       <= (write_r && !err_r) ? ST_GAP : ST_END;
              idle_cnt_r <= bus_seq_pkg::IDLE_PHASES;
            end else begin
              reads_left_r <= reads_left_r - 2'h1;
              st_r         <= ST_S0; // RULE9
            end
          end else begin
            st_r <= ST_END; // RULE17
          end
        end
        ST_GAP: begin
          if (idle_cnt_r == 4'h0) begin
            st_r     <= ST_S0;
            wphase_r <= 1'b1; // RULE12
          end else begin
            idle_cnt_r <= idle_cnt_r - 4'h1;
          end
        end
        ST_END:  st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Operation parameters captured at start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_r    <= bus_seq_pkg::OP_RMW;
      write_r <= 1'b0;
      waddr_r <= bus_seq_pkg::ADDR_RESET;
      wdata_r <= bus_seq_pkg::DATA_RESET;
      wsize_r <= bus_seq_pkg::SIZE_WORD;
    end else if (st_r == ST_IDLE && start) begin
      op_r    <= op;
      write_r <= (op == bus_seq_pkg::OP_RMW) && op_write; // RULE12
      waddr_r <= wr_addr;
      wdata_r <= wr_data;
      wsize_r <= wr_size;
    end
  end

  // Address, direction, code and size; held between phases
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      address          <= bus_seq_pkg::ADDR_RESET;
      read_write_dir   <= 1'b1;
      function_code    <= 3'h0;
      transfer_size_hi <= 1'b0;
      transfer_size_lo <= 1'b0;
    end else if (st_r == ST_IDLE && start) begin
      read_write_dir <= 1'b1; // RULE3
      if (op == bus_seq_pkg::OP_RMW) begin
        address       <= op_addr;
        function_code <= op_fc;
        {transfer_size_hi, transfer_size_lo} <= op_size;
      end else begin
        function_code <= bus_seq_pkg::FC_PRIVATE; // RULE18
        {transfer_size_hi, transfer_size_lo} <= bus_seq_pkg::SIZE_WORD;
        if (op == bus_seq_pkg::OP_HW_BREAKPOINT_PIN) begin
          address <= breakpoint_pin_addr(bus_seq_pkg::BREAKPOINT_PIN_HW_NUM, 1'b1); // RULE21
        end else begin
          address <= breakpoint_pin_addr(breakpoint_pin_num, 1'b0); // RULE19
        end
      end
    end else if (st_r == ST_GAP && idle_cnt_r == 4'h0) begin
      read_write_dir <= 1'b0; // RULE13 RULE14
      address        <= waddr_r; // RULE14
      {transfer_size_hi, transfer_size_lo} <= wsize_r;
    end
  end
  // RULE10: no branch above touches these in ST_GAP until its last phase, which loads them for write S0

  // Strobes: set at S1 entry (write data strobe after S2), cleared on entry to S5
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_strobe_n        <= 1'b1;
      data_strobe_n        <= 1'b1;
      upper_write_strobe_n <= 1'b1;
      lower_write_strobe_n <= 1'b1;
    end else if (st_r == ST_S0) begin
      addr_strobe_n <= 1'b0; // RULE4 RULE15
      data_strobe_n <= wphase_r; // RULE4
      if (wphase_r) begin
        upper_write_strobe_n <= !(wsize_r == bus_seq_pkg::SIZE_WORD ||
                                  !waddr_r[0]); // RULE15
        lower_write_strobe_n <= !(wsize_r == bus_seq_pkg::SIZE_WORD ||
                                  waddr_r[0]);
      end
    end else if (st_r == ST_S2 && wphase_r) begin
      data_strobe_n <= 1'b0; // RULE16
    end else if (st_r == ST_S4) begin
      addr_strobe_n        <= 1'b1; // RULE9 RULE17
      data_strobe_n        <= 1'b1;
      upper_write_strobe_n <= 1'b1;
      lower_write_strobe_n <= 1'b1;
    end
  end

  // Write data driven only from write S2 through ST_END
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out <= bus_seq_pkg::DATA_RESET;
      data_oe  <= 1'b0;
    end else if (st_r == ST_S1 && wphase_r) begin
      data_out <= wdata_r; // RULE15
      data_oe  <= 1'b1; // RULE13
    end else if (st_r == ST_END || st_r == ST_IDLE) begin
      data_oe <= 1'b0;
    end
  end

  // Locked flag and bus grant suppression
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      locked_r <= 1'b0;
    end else if (st_r == ST_IDLE && start && op == bus_seq_pkg::OP_RMW) begin
      locked_r <= 1'b1; // RULE1
    end else if (st_r == ST_END) begin
      locked_r <= 1'b0;
    end
  end
  assign indivisible_cycle_flag_n = !locked_r; // RULE1 RULE3
  assign bus_grant_out = bus_request_in && !locked_r &&
                         st_r == ST_IDLE; // RULE2

  // Termination capture in S2 or ST_SW; data latch at S4
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_r <= 1'b0;
    end else if (st_r == ST_S0) begin
      err_r <= 1'b0;
    end else if ((st_r == ST_S2 || st_r == ST_SW) && ack_now) begin
      err_r <= !bus_error_in_n; // RULE20 RULE21
    end
  end

  assign store_bus.wr_en   = st_r == ST_S4 && !wphase_r && !err_r; // RULE6
  assign store_bus.wr_idx  = rd_cnt_r;
  assign store_bus.wr_data = data_in; // RULE6
  assign store_bus.rd_idx  = 2'h0;

  // Completion and outcome
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done        <= 1'b0;
      result      <= bus_seq_pkg::RES_OK;
      result_data <= bus_seq_pkg::DATA_RESET;
    end else begin
      done <= st_r == ST_END;
      if (st_r == ST_END) begin
        result_data <= store_bus.rd_data; // RULE20
        if (!err_r) begin
          result <= bus_seq_pkg::RES_OK; // RULE21
        end else begin
          case (op_r)
            bus_seq_pkg::OP_SW_BREAKPOINT_PIN: result <= bus_seq_pkg::RES_ILLEGAL;
            bus_seq_pkg::OP_HW_BREAKPOINT_PIN: result <= bus_seq_pkg::RES_BREAKPOINT_PIN_EXC;
            default:                 result <= bus_seq_pkg::RES_BUS_ERR;
          endcase
        end
      end
    end
  end

  // Pin sampled with data; pending until acknowledge cycle runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      breakpoint_pin_pend_r <= 1'b0;
    end else if (st_r == ST_S4 && !breakpoint_pin_n) begin
      breakpoint_pin_pend_r <= 1'b1; // RULE22
    end else if (st_r == ST_S0 && op_r == bus_seq_pkg::OP_HW_BREAKPOINT_PIN) begin
      breakpoint_pin_pend_r <= 1'b0;
    end
  end
  assign breakpoint_pin_seen    = breakpoint_pin_pend_r;
  assign busy         = st_r != ST_IDLE;
  assign modify_phase = st_r == ST_GAP;

  property p_no_grant;
    @(posedge clk) disable iff (!rst_n)
      !indivisible_cycle_flag_n |-> !bus_grant_out;
  endproperty
  a_no_grant: assert property (p_no_grant) // RULE2
    else $error("grant while locked");

  property p_s1_strobes;
    @(posedge clk) disable iff (!rst_n)
      st_r == ST_S0 && !wphase_r |=> !addr_strobe_n && !data_strobe_n;
  endproperty
  a_s1_strobes: assert property (p_s1_strobes) // RULE4
    else $error("read strobes late");

  property p_s5_neg;
    @(posedge clk) disable iff (!rst_n)
      st_r == ST_S5 |-> addr_strobe_n && data_strobe_n;
  endproperty
  a_s5_neg: assert property (p_s5_neg) else $error("strobes in S5"); // RULE9

  property p_wait;
    @(posedge clk) disable iff (!rst_n)
      st_r == ST_S2 && !ack_now |=> st_r == ST_SW;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait state"); // RULE7

  property p_gap_quiet;
    @(posedge clk) disable iff (!rst_n)
      st_r == ST_GAP |-> addr_strobe_n && read_write_dir && !data_oe;
  endproperty
  a_gap_quiet: assert property (p_gap_quiet) // RULE12
    else $error("idle not quiet");

  property p_wr_data;
    @(posedge clk) disable iff (!rst_n)
      wphase_r && st_r == ST_S1 |=> data_oe && !read_write_dir;
  endproperty
  a_wr_data: assert property (p_wr_data) // RULE15
    else $error("write data late");

  property p_wr_ds;
    @(posedge clk) disable iff (!rst_n)
      wphase_r && st_r == ST_S2 |=> !data_strobe_n;
  endproperty
  a_wr_ds: assert property (p_wr_ds) else $error("write DS missing"); // RULE16

  property p_fc7;
    @(posedge clk) disable iff (!rst_n)
      st_r == ST_S0 && op_r != bus_seq_pkg::OP_RMW |-> function_code == 3'h7;
  endproperty
  a_fc7: assert property (p_fc7) else $error("private code wrong"); // RULE18
endmodule : bus_seq

//--- rtl/bus_seq_pkg.sv
// Constants for the indivisible and breakpoint bus cycle sequencer.
// Assumes a single 50 MHz system clock; bus states are half-clock phases.
package bus_seq_pkg;
  localparam logic [2:0]  FC_PRIVATE      = 3'h7;
  localparam logic [3:0]  SPACE_BREAKPOINT_PIN      = 4'h0;
  localparam int          SPACE_LSB       = 16;
  localparam int          BREAKPOINT_PIN_NUM_LSB    = 2;
  localparam int          BREAKPOINT_PIN_KIND_BIT   = 1;
  localparam logic [2:0]  BREAKPOINT_PIN_HW_NUM     = 3'h7;
  localparam logic [1:0]  SIZE_WORD       = 2'h2;
  localparam logic [1:0]  SIZE_BYTE       = 2'h1;
  localparam logic [31:0] ADDR_RESET      = 32'h00000000;
  localparam logic [15:0] DATA_RESET      = 16'h0000;
  localparam logic [3:0]  IDLE_PHASES     = 4'h2;
  localparam logic [1:0]  ACK_PORT8       = 2'h2;
  localparam logic [1:0]  OP_RMW          = 2'h0;
  localparam logic [1:0]  OP_SW_BREAKPOINT_PIN      = 2'h1;
  localparam logic [1:0]  OP_HW_BREAKPOINT_PIN      = 2'h2;
  localparam logic [1:0]  RES_OK          = 2'h0;
  localparam logic [1:0]  RES_ILLEGAL     = 2'h1;
  localparam logic [1:0]  RES_BREAKPOINT_PIN_EXC    = 2'h2;
  localparam logic [1:0]  RES_BUS_ERR     = 2'h3;
endpackage : bus_seq_pkg

//--- rtl/cyc_if.sv
// Carrier between the sequencer and its read data holding store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cyc_if;
  logic        wr_en;
  logic [1:0]  wr_idx;
  logic [15:0] wr_data;
  logic [1:0]  rd_idx;
  logic [15:0] rd_data;
  modport seq (output wr_en, output wr_idx, output wr_data,
               output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data,
               input rd_idx, output rd_data);
endinterface : cyc_if

//--- rtl/read_store.sv
// Small store of words latched during the read phase.
// Assumes synchronous active-low reset; read data registered.
`timescale 1ns/1ps
module read_store #(
  parameter int DEPTH = 4
) (
  input  wire logic clk,
  input  wire logic rst_n,
  cyc_if.mem        port
);
  logic [15:0] mem_r [DEPTH];

  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem_r[port.wr_idx] <= port.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port.rd_data <= bus_seq_pkg::DATA_RESET;
    end else begin
      port.rd_data <= mem_r[port.rd_idx];
    end
  end
endmodule : read_store

//--- tb/bus_slave_model.sv
// Behavioural slave on the far side of the sequencer's asynchronous bus.
// Assumes low-active strobes and the bench clock; answers after waits.
`timescale 1ns/1ps
module bus_slave_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        addr_strobe_n,
  input  wire logic        data_strobe_n,
  input  wire logic [2:0]  function_code,
  input  wire logic [3:0]  waits,
  input  wire logic        fail,
  input  wire logic        breakpoint_pin_req,
  input  wire logic [15:0] word,
  output logic [1:0]       transfer_ack_n,
  output logic             bus_error_in_n,
  output logic             breakpoint_pin_n,
  output logic [15:0]      data_in
);
  logic [3:0] cnt_r;
  logic       hit_r;
  logic       sel;
  logic       ack_cyc;
  assign sel = !addr_strobe_n || !data_strobe_n;
  assign ack_cyc = function_code == bus_seq_pkg::FC_PRIVATE && !addr_strobe_n;
  initial begin
    transfer_ack_n = 2'h3;
    bus_error_in_n = 1'b1;
    breakpoint_pin_n = 1'b1;
    data_in = 16'h5A5A;
    cnt_r = 4'h0;
    hit_r = 1'b0;
  end
  always @(posedge clk) begin
    if (!rst_n || !sel) begin
      cnt_r <= 4'h0;
      transfer_ack_n <= 2'h3;
      bus_error_in_n <= 1'b1;
      data_in <= ~data_in;
    end else if (cnt_r < waits) begin
      cnt_r <= cnt_r + 4'h1;
    end else if (fail) begin
      bus_error_in_n <= 1'b0;
    end else begin
      transfer_ack_n <= 2'h0;
      data_in <= word;
    end
  end
  // Pin held until the private-space cycle is seen
  always @(posedge clk) begin
    if (!rst_n || !breakpoint_pin_req) begin
      hit_r <= 1'b0;
      breakpoint_pin_n <= 1'b1;
    end else begin
      hit_r <= hit_r || ack_cyc;
      breakpoint_pin_n <= hit_r || ack_cyc;
    end
  end
endmodule : bus_slave_model

//--- tb/test_locked_rmw_and_breakpoint_bus_cycles.sv
// Self-checking bench for the indivisible and breakpoint cycle sequencer.
// Assumes the slave model answers on the bus side.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  err_count++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
  end end
module test_locked_rmw_and_breakpoint_bus_cycles;
  logic        clk, rst_n, start, op_write, bus_request_in, busy, done;
  logic        bus_error_in_n, breakpoint_pin_n, modify_phase, breakpoint_pin_seen;
  logic        bus_grant_out, indivisible_cycle_flag_n, addr_strobe_n;
  logic        data_strobe_n, upper_write_strobe_n, lower_write_strobe_n;
  logic        read_write_dir, transfer_size_hi, transfer_size_lo, data_oe;
  logic        fail, breakpoint_pin_req, lock, as_q;
  logic [1:0]  op, op_reads, wr_size, op_size, transfer_ack_n, result, rd_sz;
  logic [2:0]  breakpoint_pin_num, op_fc, function_code, rd_fc;
  logic [3:0]  waits, ws_seen;
  logic [15:0] wr_data, data_in, result_data, data_out, word, dat_seen;
  logic [31:0] op_addr, wr_addr, address, rd_addr, wr_seen, exp_a;
  int          err_count, comparisons, n_rd, n_wr, bad, n_mod;

  bus_seq u_bus_seq (.clk, .rst_n, .start, .op, .op_addr, .op_reads,
    .op_write, .wr_addr, .wr_data, .wr_size, .breakpoint_pin_num, .op_fc, .op_size,
    .bus_request_in, .transfer_ack_n, .bus_error_in_n, .breakpoint_pin_n,
    .data_in, .busy, .done, .result, .result_data, .modify_phase,
    .breakpoint_pin_seen, .bus_grant_out, .indivisible_cycle_flag_n, .addr_strobe_n,
    .data_strobe_n, .upper_write_strobe_n, .lower_write_strobe_n,
    .read_write_dir, .address, .function_code, .transfer_size_hi,
    .transfer_size_lo, .data_out, .data_oe);
  bus_slave_model u_bus_slave_model (.clk, .rst_n, .addr_strobe_n,
    .data_strobe_n, .function_code, .waits, .fail, .breakpoint_pin_req, .word,
    .transfer_ack_n, .bus_error_in_n, .breakpoint_pin_n, .data_in);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Bus watcher: cycle counts, first read setup, write setup and data
  always @(posedge clk) begin
    as_q <= addr_strobe_n;
    if (as_q && !addr_strobe_n && read_write_dir) begin
      if (n_rd == 0) begin
        rd_addr = address;
        rd_fc = function_code;
        rd_sz = {transfer_size_hi, transfer_size_lo};
      end
      n_rd++;
    end
    if (as_q && !addr_strobe_n && !read_write_dir) begin
      n_wr++;
      wr_seen = address;
      ws_seen = {data_oe, data_strobe_n,
                 upper_write_strobe_n, lower_write_strobe_n};
    end
    if (data_oe) dat_seen = data_out;
    if (data_oe && read_write_dir) bad++;
    if (lock && !addr_strobe_n && indivisible_cycle_flag_n) bad++;
    if (!indivisible_cycle_flag_n && bus_grant_out) bad++;
    if (modify_phase) n_mod++;
    if (modify_phase && !(addr_strobe_n && data_strobe_n)) bad++;
  end

  task automatic complete_run();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic run(input logic [1:0] o, input logic f, input logic [3:0] w);
    int i;
    n_rd = 0;
    n_wr = 0;
    bad = 0;
    n_mod = 0;
    op = o;
    fail = f;
    waits = w;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    for (i = 0; i < 300 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      err_count++;
      complete_run();
    end
  endtask : run

  task automatic t_reset();
    logic [3:0] strb;
    strb = {addr_strobe_n, data_strobe_n, upper_write_strobe_n,
            lower_write_strobe_n};
    `CHK("strobes", 4'hF, strb)
    `CHK("flag busy", 2'h1, {busy, indivisible_cycle_flag_n})
  endtask : t_reset

  task automatic t_rmw_write();
    lock = 1'b1;
    bus_request_in = 1'b1;
    op_reads = 2'h1;
    op_write = 1'b1;
    run(bus_seq_pkg::OP_RMW, 1'b0, 4'h0);
    `CHK("reads", 1, n_rd)
    `CHK("writes", 1, n_wr)
    `CHK("rd addr", op_addr, rd_addr)
    `CHK("rd fc", op_fc, rd_fc)
    `CHK("rd size", op_size, rd_sz)
    `CHK("rd data", word, result_data)
    `CHK("result", bus_seq_pkg::RES_OK, result)
    `CHK("wr addr", wr_addr, wr_seen)
    `CHK("wr data", wr_data, dat_seen)
    `CHK("wr strobes", 4'h4, ws_seen)
    `CHK("modify", bus_seq_pkg::IDLE_PHASES + 1, n_mod)
    `CHK("locked", 0, bad)
    @(posedge clk);
    #1;
    `CHK("grant", 2'h3, {bus_grant_out, indivisible_cycle_flag_n})
    lock = 1'b0;
  endtask : t_rmw_write

  task automatic t_rmw_wait();
    lock = 1'b1;
    breakpoint_pin_req = 1'b1;
    op_reads = 2'h2;
    op_write = 1'b0;
    run(bus_seq_pkg::OP_RMW, 1'b0, 4'h3);
    `CHK("reads", 2, n_rd)
    `CHK("writes", 0, n_wr)
    `CHK("modify", 0, n_mod)
    `CHK("pin seen", 1'b1, breakpoint_pin_seen)
    `CHK("rd data", word, result_data)
    `CHK("held addr", op_addr, address)
    `CHK("dir fc", {1'b1, op_fc}, {read_write_dir, function_code})
    `CHK("locked", 0, bad)
    lock = 1'b0;
  endtask : t_rmw_wait

  task automatic t_breakpoint_pin();
    logic [1:0] exp_r;
    logic [1:0] bk_op;
    for (int k = 0; k < 4; k++) begin
      breakpoint_pin_req = k[1];
      bk_op = k[1] ? bus_seq_pkg::OP_HW_BREAKPOINT_PIN : bus_seq_pkg::OP_SW_BREAKPOINT_PIN;
      @(posedge clk);
      #1;
      run(bk_op, k[0], 4'h1);
      exp_a = (32'(bus_seq_pkg::SPACE_BREAKPOINT_PIN) << bus_seq_pkg::SPACE_LSB)
        | (32'(k[1] ? bus_seq_pkg::BREAKPOINT_PIN_HW_NUM : breakpoint_pin_num)
           << bus_seq_pkg::BREAKPOINT_PIN_NUM_LSB)
        | (32'(k[1]) << bus_seq_pkg::BREAKPOINT_PIN_KIND_BIT);
      exp_r = k[1] ? (k[0] ? bus_seq_pkg::RES_BREAKPOINT_PIN_EXC : bus_seq_pkg::RES_OK)
        : (k[0] ? bus_seq_pkg::RES_ILLEGAL : bus_seq_pkg::RES_OK);
      `CHK("bk addr", exp_a, rd_addr)
      `CHK("bk fc", bus_seq_pkg::FC_PRIVATE, rd_fc)
      `CHK("bk size", bus_seq_pkg::SIZE_WORD, rd_sz)
      `CHK("bk result", exp_r, result)
      if (k == 0) `CHK("bk word", word, result_data)
      `CHK("bk pend", !k[1], breakpoint_pin_seen)
    end
    breakpoint_pin_req = 1'b0;
  endtask : t_breakpoint_pin

  initial begin
    err_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    start = 1'b0;
    op = bus_seq_pkg::OP_RMW;
    op_addr = 32'h00012344;
    op_fc = 3'h5;
    op_size = bus_seq_pkg::SIZE_WORD;
    op_reads = 2'h1;
    op_write = 1'b0;
    wr_addr = 32'h00012346;
    wr_data = 16'hBEEF;
    wr_size = bus_seq_pkg::SIZE_WORD;
    breakpoint_pin_num = 3'h5;
    bus_request_in = 1'b0;
    fail = 1'b0;
    breakpoint_pin_req = 1'b0;
    lock = 1'b0;
    waits = 4'h0;
    word = 16'h1234;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_rmw_write();
    t_rmw_wait();
    t_breakpoint_pin();
    complete_run();
  end
endmodule : test_locked_rmw_and_breakpoint_bus_cycles
